// [bench/wad_core_bench.sv]
/*
  Self-checking bench for the wide add datapath: immediate, pair and memory adds.
  Assumes wad_core with combinational memory read data and a code stream with valid.
*/
`timescale 1ns/1ps
module wad_core_bench;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ce = 1'b1;
  logic i_code_valid = 1'b0;
  logic [7:0] i_code_byte = 8'h00;
  logic i_decimal_mode = 1'b0;
  logic i_unpacked_mode = 1'b0;
  logic i_paged_model = 1'b0;
  logic [7:0] i_data_page = 8'h3C;
  logic [7:0] i_x_page = 8'h5A;
  logic [7:0] i_y_page = 8'h69;
  logic i_pair_wr = 1'b0;
  logic [2:0] i_pair_sel = 3'h0;
  logic [15:0] i_pair_wdata = 16'h0000;
  logic [7:0] i_mem_rdata;
  logic o_code_take, o_busy, o_done, o_illegal, o_mem_rd, o_mem_wr;
  logic [15:0] o_mem_addr;
  logic [7:0] o_mem_page, o_mem_wdata;
  logic [15:0] pout [0:4];
  logic o_flag_negative, o_flag_overflow, o_flag_carry, o_flag_zero;
  logic [3:0] flg;
  logic [7:0] mem [0:255];
  logic [15:0] rd_addr [0:1];
  logic [7:0] rd_page [0:1];
  logic [15:0] wr_addr;
  int rd_n = 0;
  logic [15:0] pv [0:4];
  int fail_count = 0;
  int n_compared = 0;
  localparam logic [15:0] VA [4] = '{16'h1380, 16'h1380, 16'h5218, 16'h5342};
  localparam logic [15:0] VB [4] = '{16'h3546, 16'hEC80, 16'h4174, 16'hC32A};
  localparam logic [7:0] SUBS [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h20, 8'h21, 8'h22, 8'h23,
                                       8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45};
  // Byte add cases as destination, source, sum, flags N V C Z.
  localparam logic [7:0] MA [6] = '{8'h18, 8'h30, 8'h30, 8'h30, 8'h18, 8'h18};
  localparam logic [7:0] MB [6] = '{8'h25, 8'hD0, 8'hF0, 8'h50, 8'h24, 8'h24};
  localparam logic [7:0] MR [6] = '{8'h3D, 8'h00, 8'h20, 8'h80, 8'h42, 8'h02};
  localparam logic [3:0] MF [6] = '{4'h0, 4'h3, 4'h2, 4'hC, 4'h0, 4'h2};

  always #10 i_clock = ~i_clock;
  assign flg = {o_flag_negative, o_flag_overflow, o_flag_carry, o_flag_zero};
  // Outside a read the data lines show a pattern, so a late sample cannot pass by luck.
  assign i_mem_rdata = o_mem_rd ? mem[o_mem_addr[7:0]] : ~o_mem_addr[7:0];

  always @(posedge i_clock) begin
    if (o_mem_rd && rd_n < 2) begin
      rd_addr[rd_n] <= o_mem_addr;
      rd_page[rd_n] <= o_mem_page;
      rd_n <= rd_n + 1;
    end
    if (o_mem_wr) begin
      wr_addr <= o_mem_addr;
      mem[o_mem_addr[7:0]] <= o_mem_wdata;
    end
  end

  wad_core dut_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_ce(i_ce), .i_code_valid(i_code_valid),
    .i_code_byte(i_code_byte), .o_code_take(o_code_take), .o_busy(o_busy), .o_done(o_done),
    .o_illegal(o_illegal), .i_decimal_mode(i_decimal_mode), .i_unpacked_mode(i_unpacked_mode),
    .i_paged_model(i_paged_model), .i_data_page(i_data_page), .i_x_page(i_x_page),
    .i_y_page(i_y_page), .i_pair_wr(i_pair_wr), .i_pair_sel(i_pair_sel), .i_pair_wdata(i_pair_wdata),
    .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_page(o_mem_page),
    .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .o_acc_pair(pout[0]),
    .o_pointer_pair(pout[1]), .o_index_x(pout[2]), .o_index_y(pout[3]), .o_stack_pointer(pout[4]),
    .o_flag_negative(o_flag_negative), .o_flag_overflow(o_flag_overflow),
    .o_flag_carry(o_flag_carry), .o_flag_zero(o_flag_zero));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Result and flags N V C Z of a plain 16-bit binary add.
  function automatic logic [19:0] add16(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return {s[15], (a[15] == b[15]) && (s[15] != a[15]), s[16], s[15:0] == 16'h0000, s[15:0]};
  endfunction

  task automatic setp(input int k, input logic [15:0] v);
    i_pair_sel = 3'(k);
    i_pair_wdata = v;
    i_pair_wr = 1'b1;
    @(posedge i_clock);
    #1 i_pair_wr = 1'b0;
    pv[k] = v;
    @(posedge i_clock);
    #1;
  endtask

  task automatic chk_pairs();
    for (int k = 0; k < 5; k++) check(32'(pout[k]), 32'(pv[k]));
  endtask

  // Sends nb code bytes, low byte of b first; cyc is the cycle of done counted from the opcode.
  task automatic run(input logic [39:0] b, input int nb, output int cyc, output logic ill);
    int i;
    logic took;
    i = 0;
    cyc = -1;
    ill = 1'b0;
    // An idle edge first keeps back-to-back calls from driving the strobe twice at once.
    @(posedge i_clock);
    #1;
    i_code_byte = b[7:0];
    i_code_valid = 1'b1;
    for (int c = 0; c < 20 && cyc < 0; c++) begin
      // Outputs are read one step after the inputs move, once the decode has settled.
      #1;
      if (o_done === 1'b1) cyc = c;
      if (o_illegal === 1'b1) begin
        ill = 1'b1;
        cyc = c;
      end
      took = (o_code_take === 1'b1);
      @(posedge i_clock);
      #1;
      if (took) begin
        i++;
        i_code_byte = b[8*i +: 8];
        i_code_valid = (i < nb);
      end
    end
    if (i_code_valid) i_code_valid = 1'b0;
  endtask

  task automatic test_imm();
    logic [19:0] r;
    int cyc;
    logic ill;
    for (int op = 0; op < 4; op++) begin
      for (int row = 0; row < 4; row++) begin
        setp(op, VA[row]);
        r = add16(VA[row], VB[row]);
        run({8'h00, VB[row], wad_pkg::OP_ACC_IMM + 8'(op)}, 3, cyc, ill);
        pv[op] = r[15:0];
        check(32'(cyc), 32'd2);
        check(32'(o_busy), 32'h0);
        chk_pairs();
        check(32'(flg), 32'(r[19:16]));
      end
    end
    $display("immediate adds finished");
  endtask

  task automatic test_pair();
    logic [19:0] r;
    int cyc, d, s;
    logic ill;
    for (int n = 0; n < 14; n++) begin
      for (int k = 0; k < 5; k++) setp(k, VA[k % 4] ^ VB[(k + 1) % 4]);
      d = SUBS[n] < 8'h04 ? 0 : SUBS[n] < 8'h24 ? 1 : 2 + ((SUBS[n] - 8'h40) >> 1);
      s = SUBS[n] < 8'h24 ? int'(SUBS[n][1:0]) : int'(SUBS[n][0]);
      r = add16(pv[d], pv[s]);
      run({24'h000000, SUBS[n], wad_pkg::OP_PREFIX_EXT}, 2, cyc, ill);
      pv[d] = r[15:0];
      check(32'(cyc), 32'd3);
      chk_pairs();
      check(32'(flg), 32'(r[19:16]));
    end
    setp(4, 16'h5342);
    r = add16(16'h5342, 16'hC32A);
    run({8'h00, 16'hC32A, wad_pkg::SUB_SP_IMM, wad_pkg::OP_PREFIX_EXT}, 4, cyc, ill);
    pv[4] = r[15:0];
    check(32'(cyc), 32'd3);
    chk_pairs();
    check(32'(flg), 32'(r[19:16]));
    for (int n = 0; n < 2; n++) begin
      r[3:0] = flg;
      run({24'h000000, 8'h46 + 8'(n), wad_pkg::OP_PREFIX_EXT}, 2, cyc, ill);
      check(32'(ill), 32'd1);
      check(32'(o_busy), 32'h0);
      chk_pairs();
      check(32'(flg), 32'(r[3:0]));
    end
    run(40'h00000000C4, 1, cyc, ill);
    check(32'(ill), 32'h1);
    check(32'(o_busy), 32'h0);
    $display("pair adds finished");
  endtask

  task automatic test_mem();
    int cyc, ir;
    logic ill;
    logic paged;
    setp(1, 16'h0010);
    setp(2, 16'h0020);
    setp(3, 16'h0030);
    for (int row = 0; row < 6; row++) begin
      ir = row % 2;
      paged = (row != 5);
      mem[8'h10] = MA[row];
      mem[8'h20 + 8'(16 * ir)] = MB[row];
      i_paged_model = paged;
      i_decimal_mode = (row >= 4);
      i_unpacked_mode = (row == 5);
      rd_n = 0;
      run({32'h00000000, 8'h06 + 8'(ir)} << 8 | 40'hCE, 2, cyc, ill);
      check(32'(cyc), 32'd4);
      check(32'(rd_addr[0]), ir ? 32'h30 : 32'h20);
      check(32'(rd_addr[1]), 32'h10);
      check(32'(rd_page[0]), !paged ? 32'h00 : ir ? 32'h69 : 32'h5A);
      check(32'(rd_page[1]), paged ? 32'h3C : 32'h00);
      check(32'(wr_addr), 32'h10);
      check(32'(mem[8'h10]), 32'(MR[row]));
      check(32'(flg), 32'(MF[row]));
      chk_pairs();
    end
    $display("memory adds finished");
  endtask

  // A preload offered while the clock enable is low must leave every pair as it was.
  task automatic test_ce();
    i_ce = 1'b0;
    i_pair_sel = 3'h0;
    i_pair_wdata = 16'hFFFF;
    i_pair_wr = 1'b1;
    @(posedge i_clock);
    #1 i_pair_wr = 1'b0;
    chk_pairs();
    @(posedge i_clock);
    #1 i_ce = 1'b1;
    $display("clock enable test finished");
  endtask

  initial begin
    for (int k = 0; k < 5; k++) pv[k] = 16'h0000;
    for (int a = 0; a < 256; a++) mem[a] = 8'(a);
    repeat (6) @(posedge i_clock);
    #1 i_rstn = 1'b1;
    chk_pairs();
    check(32'(flg), 32'h0);
    test_ce();
    test_imm();
    test_pair();
    test_mem();
    tally_and_finish();
  end

  // The whole run needs well under a thousand cycles; this limit leaves a wide margin.
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
endmodule // wad_core_bench

// [core/wad_alu.sv]
/*
  Combinational adder for the wide add datapath: a 16-bit binary add and an
  8-bit add with optional packed or unpacked decimal correction.
  Assumes operands are stable within one core clock cycle.
*/
`timescale 1ns/1ps
module wad_alu (
  // Wide operands
  input wire logic [15:0] i_a16,
  input wire logic [15:0] i_b16,
  // Byte operands and modes
  input wire logic [7:0] i_a8,
  input wire logic [7:0] i_b8,
  input wire logic i_decimal,
  input wire logic i_unpacked,
  // Results, flags as N V C Z
  output logic [15:0] o_sum16,
  output logic [3:0] o_flags16,
  output logic [7:0] o_sum8,
  output logic [3:0] o_flags8
);
  logic [16:0] wide;
  logic [8:0] bin8;
  logic [4:0] lo;
  logic [4:0] hi;
  logic clo;
  logic chi;

  always_comb begin
    // Decimal and unpacked modes are deliberately ignored here.
    wide = {1'b0, i_a16} + {1'b0, i_b16};
    o_sum16 = wide[15:0];
    o_flags16[wad_pkg::FLG_N] = wide[15];
    o_flags16[wad_pkg::FLG_C] = wide[16];
    o_flags16[wad_pkg::FLG_V] = (i_a16[15] == i_b16[15]) && (wide[15] != i_a16[15]);
    o_flags16[wad_pkg::FLG_Z] = (wide[15:0] == 16'h0000);
  end

  always_comb begin
    bin8 = {1'b0, i_a8} + {1'b0, i_b8};
    lo = {1'b0, i_a8[3:0]} + {1'b0, i_b8[3:0]};
    clo = lo > wad_pkg::BCD_LIMIT;
    if (clo) begin
      lo = lo + wad_pkg::BCD_ADJ;
    end
    hi = {1'b0, i_a8[7:4]} + {1'b0, i_b8[7:4]} + {4'h0, clo};
    chi = hi > wad_pkg::BCD_LIMIT;
    if (chi) begin
      hi = hi + wad_pkg::BCD_ADJ;
    end
    if (!i_decimal) begin
      o_sum8 = bin8[7:0];
      o_flags8[wad_pkg::FLG_C] = bin8[8];
      o_flags8[wad_pkg::FLG_V] = (i_a8[7] == i_b8[7]) && (bin8[7] != i_a8[7]);
    end else if (i_unpacked) begin
      // Unpacked digits use only the low nibble; the carry is the digit carry.
      o_sum8 = {4'h0, lo[3:0]};
      o_flags8[wad_pkg::FLG_C] = clo;
      o_flags8[wad_pkg::FLG_V] = 1'b0;
    end else begin
      o_sum8 = {hi[3:0], lo[3:0]};
      o_flags8[wad_pkg::FLG_C] = chi;
      o_flags8[wad_pkg::FLG_V] = 1'b0;
    end
    o_flags8[wad_pkg::FLG_N] = o_sum8[7];
    o_flags8[wad_pkg::FLG_Z] = (o_sum8 == 8'h00);
  end
endmodule // wad_alu

// [core/wad_core.sv]
/*
  Execution logic for the group of wide add instructions and the memory to
  memory byte add. Holds the five 16-bit pairs and the four condition flags.
  Assumes a fetch unit on the same clock that presents code bytes with a
  valid bit, and a data memory with combinational read data.
*/
`timescale 1ns/1ps
module wad_core (
  // Clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Code byte stream
  input wire logic i_code_valid,
  input wire logic [7:0] i_code_byte,
  output logic o_code_take,
  // Status
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  // Modes and pages
  input wire logic i_decimal_mode,
  input wire logic i_unpacked_mode,
  input wire logic i_paged_model,
  input wire logic [7:0] i_data_page,
  input wire logic [7:0] i_x_page,
  input wire logic [7:0] i_y_page,
  // Pair preload
  input wire logic i_pair_wr,
  input wire logic [2:0] i_pair_sel,
  input wire logic [15:0] i_pair_wdata,
  // Data memory
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_page,
  output logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  // Register pairs and flags
  output logic [15:0] o_acc_pair,
  output logic [15:0] o_pointer_pair,
  output logic [15:0] o_index_x,
  output logic [15:0] o_index_y,
  output logic [15:0] o_stack_pointer,
  output logic o_flag_negative,
  output logic o_flag_overflow,
  output logic o_flag_carry,
  output logic o_flag_zero
);
  wad_pkg::wad_state_t state_r;
  wad_pkg::wad_dst_t dst_r;
  logic [2:0] cyc_r;
  logic [2:0] len_r;
  logic [1:0] src_r;
  logic is_imm_r;
  logic index_select_r;
  logic [7:0] prefix_r;
  logic [7:0] imm_lo_r;
  logic [7:0] src_byte_r;
  logic [3:0] mem_flags_r;
  logic [3:0] flags_r;
  logic [15:0] pair_r [5];
  logic need_byte;
  logic adv;
  logic last;
  logic [15:0] opnd_b;
  logic [15:0] sum16;
  logic [3:0] flags16;
  logic [7:0] sum8;
  logic [3:0] flags8;

  // Selects a source pair from the two-bit source_pair_field.
  function automatic logic [15:0] pair_by_field(input logic [1:0] f, input logic [15:0] acc,
    input logic [15:0] ptr, input logic [15:0] ix, input logic [15:0] iy);
    unique case (f)
      wad_pkg::SRC_ACC: pair_by_field = acc;
      wad_pkg::SRC_PTR: pair_by_field = ptr;
      wad_pkg::SRC_IDX_X: pair_by_field = ix;
      wad_pkg::SRC_IDX_Y: pair_by_field = iy;
    endcase
  endfunction

  assign last = (cyc_r == len_r - wad_pkg::CYC_ONE);
  assign need_byte = (state_r == wad_pkg::ST_IDLE) || (state_r == wad_pkg::ST_SUB) ||
    ((state_r == wad_pkg::ST_EXEC) && is_imm_r && (cyc_r >= len_r - wad_pkg::CYC_TWO));
  // A missing code byte stalls the sequence rather than corrupting it.
  assign adv = i_ce && (!need_byte || i_code_valid);
  assign o_code_take = adv && need_byte;
  assign o_busy = (state_r != wad_pkg::ST_IDLE);
  assign o_done = adv && (state_r == wad_pkg::ST_EXEC) && last;
  assign opnd_b = is_imm_r ? {i_code_byte, imm_lo_r} :
    pair_by_field(src_r, pair_r[wad_pkg::DST_ACC], pair_r[wad_pkg::DST_PTR],
    pair_r[wad_pkg::DST_IDX_X], pair_r[wad_pkg::DST_IDX_Y]);

  always_comb begin
    o_illegal = 1'b0;
    if (adv && (state_r == wad_pkg::ST_IDLE)) begin
      o_illegal = !(i_code_byte[7:2] == wad_pkg::OP_ACC_IMM[7:2] ||
        i_code_byte == wad_pkg::OP_PREFIX_MEM || i_code_byte == wad_pkg::OP_PREFIX_EXT);
    end else if (adv && (state_r == wad_pkg::ST_SUB)) begin
      if (prefix_r == wad_pkg::OP_PREFIX_MEM) begin
        o_illegal = i_code_byte[7:1] != wad_pkg::SUB_MEM_ADD;
      end else begin
        o_illegal = !(i_code_byte[7:2] == wad_pkg::SUB_ACC_RP || i_code_byte[7:2] == wad_pkg::SUB_PTR_RP ||
          i_code_byte[7:1] == wad_pkg::SUB_IDX_X_RP || i_code_byte[7:1] == wad_pkg::SUB_IDX_Y_RP ||
          i_code_byte[7:1] == wad_pkg::SUB_SP_RP || i_code_byte == wad_pkg::SUB_SP_IMM);
      end
    end
  end

  wad_alu u_alu (
    .i_a16(pair_r[dst_r]),
    .i_b16(opnd_b),
    .i_a8(i_mem_rdata),
    .i_b8(src_byte_r),
    .i_decimal(i_decimal_mode),
    .i_unpacked(i_unpacked_mode),
    .o_sum16(sum16),
    .o_flags16(flags16),
    .o_sum8(sum8),
    .o_flags8(flags8)
  );

  // Instruction sequencing and decode.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= wad_pkg::ST_IDLE;
      dst_r <= wad_pkg::DST_ACC;
      cyc_r <= 3'h0;
      len_r <= wad_pkg::LEN_IMM;
      src_r <= wad_pkg::SRC_ACC;
      is_imm_r <= 1'b0;
      index_select_r <= 1'b0;
      prefix_r <= 8'h00;
    end else if (adv && !o_illegal) begin
      unique case (state_r)
        wad_pkg::ST_IDLE: begin
          prefix_r <= i_code_byte;
          cyc_r <= wad_pkg::CYC_FIRST;
          if (i_code_byte == wad_pkg::OP_PREFIX_MEM || i_code_byte == wad_pkg::OP_PREFIX_EXT) begin
            state_r <= wad_pkg::ST_SUB;
          end else begin
            // Low two bits of C0H..C3H pick the destination pair.
            state_r <= wad_pkg::ST_EXEC;
            dst_r <= wad_pkg::wad_dst_t'({1'b0, i_code_byte[1:0]});
            is_imm_r <= 1'b1;
            len_r <= wad_pkg::LEN_IMM;
          end
        end
        wad_pkg::ST_SUB: begin
          state_r <= wad_pkg::ST_EXEC;
          cyc_r <= wad_pkg::CYC_EXEC;
          is_imm_r <= 1'b0;
          len_r <= wad_pkg::LEN_RP;
          src_r <= {1'b0, i_code_byte[0]};
          if (prefix_r == wad_pkg::OP_PREFIX_MEM) begin
            dst_r <= wad_pkg::DST_MEM;
            index_select_r <= i_code_byte[0];
            len_r <= wad_pkg::LEN_MEM;
          end else if (i_code_byte[7:2] == wad_pkg::SUB_ACC_RP) begin
            dst_r <= wad_pkg::DST_ACC;
            src_r <= i_code_byte[1:0];
          end else if (i_code_byte[7:2] == wad_pkg::SUB_PTR_RP) begin
            dst_r <= wad_pkg::DST_PTR;
            src_r <= i_code_byte[1:0];
          end else if (i_code_byte[7:1] == wad_pkg::SUB_IDX_X_RP) begin
            dst_r <= wad_pkg::DST_IDX_X;
          end else if (i_code_byte[7:1] == wad_pkg::SUB_IDX_Y_RP) begin
            dst_r <= wad_pkg::DST_IDX_Y;
          end else if (i_code_byte[7:1] == wad_pkg::SUB_SP_RP) begin
            dst_r <= wad_pkg::DST_SP;
          end else begin
            dst_r <= wad_pkg::DST_SP;
            is_imm_r <= 1'b1;
            len_r <= wad_pkg::LEN_SP_IMM;
          end
        end
        wad_pkg::ST_EXEC: begin
          cyc_r <= cyc_r + wad_pkg::CYC_ONE;
          if (last) begin
            state_r <= wad_pkg::ST_IDLE;
          end
        end
      endcase
    end else if (adv && o_illegal) begin
      // Dropping a half-decoded prefix keeps the next opcode from being read as a second byte.
      state_r <= wad_pkg::ST_IDLE;
    end
  end

  // Immediate low byte arrives first and is held for the final cycle.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      imm_lo_r <= 8'h00;
    end else if (adv && (state_r == wad_pkg::ST_EXEC) && is_imm_r && !last) begin
      imm_lo_r <= i_code_byte;
    end
  end

  // Register pairs: an executing add wins over a preload in the same cycle.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 5; i++) begin
        pair_r[i] <= wad_pkg::PAIR_RST;
      end
    end else begin
      if (i_ce && i_pair_wr && (i_pair_sel <= wad_pkg::DST_SP)) begin
        pair_r[i_pair_sel] <= i_pair_wdata;
      end
      if (o_done && (dst_r != wad_pkg::DST_MEM)) begin
        pair_r[dst_r] <= sum16;
      end
    end
  end

  // Condition flags; interrupt flags live elsewhere and are never touched.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_r <= wad_pkg::FLAGS_RST;
    end else if (o_done) begin
      flags_r <= (dst_r == wad_pkg::DST_MEM) ? mem_flags_r : flags16;
    end
  end

  // Memory byte add: read source in cycle 2, destination in 3, write in 4.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_addr <= 16'h0000;
      o_mem_page <= wad_pkg::PAGE_FLAT;
      o_mem_wdata <= 8'h00;
      src_byte_r <= 8'h00;
      mem_flags_r <= wad_pkg::FLAGS_RST;
    end else if (adv) begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      if ((state_r == wad_pkg::ST_SUB) && (prefix_r == wad_pkg::OP_PREFIX_MEM) && !o_illegal) begin
        o_mem_rd <= 1'b1;
        o_mem_addr <= i_code_byte[0] ? pair_r[wad_pkg::DST_IDX_Y] : pair_r[wad_pkg::DST_IDX_X];
        o_mem_page <= !i_paged_model ? wad_pkg::PAGE_FLAT : (i_code_byte[0] ? i_y_page : i_x_page);
      end else if ((state_r == wad_pkg::ST_EXEC) && (dst_r == wad_pkg::DST_MEM)) begin
        if (cyc_r == wad_pkg::CYC_SRC_RD) begin
          src_byte_r <= i_mem_rdata;
          o_mem_rd <= 1'b1;
          o_mem_addr <= pair_r[wad_pkg::DST_PTR];
          o_mem_page <= i_paged_model ? i_data_page : wad_pkg::PAGE_FLAT;
        end else if (cyc_r == wad_pkg::CYC_DST_RD) begin
          o_mem_wr <= 1'b1;
          o_mem_wdata <= sum8;
          mem_flags_r <= flags8;
        end
      end
    end
  end

  assign o_acc_pair = pair_r[wad_pkg::DST_ACC];
  assign o_pointer_pair = pair_r[wad_pkg::DST_PTR];
  assign o_index_x = pair_r[wad_pkg::DST_IDX_X];
  assign o_index_y = pair_r[wad_pkg::DST_IDX_Y];
  assign o_stack_pointer = pair_r[wad_pkg::DST_SP];
  assign o_flag_negative = flags_r[wad_pkg::FLG_N];
  assign o_flag_overflow = flags_r[wad_pkg::FLG_V];
  assign o_flag_carry = flags_r[wad_pkg::FLG_C];
  assign o_flag_zero = flags_r[wad_pkg::FLG_Z];

  // Checks.
  logic mem_start;
  logic imm_start;
  logic sp_imm_start;
  assign mem_start = adv && (state_r == wad_pkg::ST_IDLE) && (i_code_byte == wad_pkg::OP_PREFIX_MEM);
  assign imm_start = adv && !o_illegal && (state_r == wad_pkg::ST_IDLE) &&
    (i_code_byte[7:2] == wad_pkg::OP_ACC_IMM[7:2]);
  assign sp_imm_start = adv && (state_r == wad_pkg::ST_SUB) && (prefix_r == wad_pkg::OP_PREFIX_EXT) &&
    (i_code_byte == wad_pkg::SUB_SP_IMM);

  a_mem_five_cycles: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (mem_start ##1 (o_code_take && !o_illegal) ##1 i_ce[*2]) |=> (i_ce |-> (o_done && o_mem_wr)))
    else $error("memory add did not finish in five cycles");
  a_mem_src_addr: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (o_mem_rd && cyc_r == wad_pkg::CYC_SRC_RD) |->
    o_mem_addr == (index_select_r ? pair_r[wad_pkg::DST_IDX_Y] : pair_r[wad_pkg::DST_IDX_X]))
    else $error("memory add source address not from index pair");
  a_mem_dst_addr: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (o_mem_rd && cyc_r == wad_pkg::CYC_DST_RD) ##1 o_mem_wr |-> o_mem_addr == pair_r[wad_pkg::DST_PTR])
    else $error("memory add destination address not pointer_pair");
  a_mem_src_page: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (o_mem_rd && cyc_r == wad_pkg::CYC_SRC_RD && $past(i_paged_model)) |->
    o_mem_page == (index_select_r ? $past(i_y_page) : $past(i_x_page)))
    else $error("memory add source page wrong");
  a_imm_three_cycles: assert property (@(posedge i_clock) disable iff (!i_rstn)
    imm_start ##1 (i_ce && i_code_valid)[*2] |-> o_done)
    else $error("immediate add did not finish in three cycles");
  a_sp_imm_four: assert property (@(posedge i_clock) disable iff (!i_rstn)
    sp_imm_start ##1 (i_ce && i_code_valid)[*2] |-> (o_done && dst_r == wad_pkg::DST_SP))
    else $error("stack pointer immediate add did not finish in four cycles");
  a_acc_imm_sum: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (o_done && is_imm_r && dst_r == wad_pkg::DST_ACC && !i_pair_wr) |=>
    o_acc_pair == $past(o_acc_pair) + {$past(i_code_byte), $past(imm_lo_r)})
    else $error("acc_pair immediate sum wrong");
  a_wide_zero_flag: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (o_done && dst_r != wad_pkg::DST_MEM) |=> (o_flag_zero == ($past(sum16) == 16'h0000)) &&
    (o_flag_negative == $past(sum16[15])))
    else $error("wide add zero or negative flag wrong");
  a_mem_flag_zero: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (o_mem_wr && o_done) |=> o_flag_zero == ($past(o_mem_wdata) == 8'h00))
    else $error("memory add zero flag wrong");
  a_index_src_limit: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_r == wad_pkg::ST_EXEC && !is_imm_r && dst_r inside {wad_pkg::DST_IDX_X, wad_pkg::DST_IDX_Y,
    wad_pkg::DST_SP}) |-> !src_r[1])
    else $error("index or stack add took an index source");

  c_mem_add: cover property (@(posedge i_clock) disable iff (!i_rstn) o_done && o_mem_wr);
  c_imm_add: cover property (@(posedge i_clock) disable iff (!i_rstn) o_done && is_imm_r);
  c_sp_pair: cover property (@(posedge i_clock) disable iff (!i_rstn)
    o_done && !is_imm_r && dst_r == wad_pkg::DST_SP);
  c_illegal: cover property (@(posedge i_clock) disable iff (!i_rstn) o_illegal);
endmodule // wad_core

// [shared/wad_pkg.sv]
/*
  Constants for the wide add datapath: opcodes, instruction lengths,
  operand select codes and flag positions.
  Assumes a single 50 MHz core clock and the core's active-low reset.
*/
// Operation
// - Memory byte add reads [index], adds to [pointer_pair], writes back, five cycles.
// - Source address from index_x or index_y, destination address from pointer_pair.
// - Paged models: destination page data_page_reg, source page x or y page.
// - Memory add decodes from CEH then 06H or 07H; low bit picks index.
// - Pair add into acc_pair from acc_pair, pointer_pair, index_x or index_y.
// - Immediate add into acc_pair fetches low then high byte, three cycles.
// - Pair add into pointer_pair from any of four pairs, four cycles.
// - Immediate add into pointer_pair takes three cycles.
// - Pair add into index_x accepts only acc_pair or pointer_pair.
// - Immediate add into index_x takes three cycles.
// - Pair add into index_y accepts only acc_pair or pointer_pair.
// - Immediate add into index_y decodes from C3H, low then high, three cycles.
// - Immediate add into stack_pointer takes four cycles.
package wad_pkg;
  localparam logic [7:0] OP_PREFIX_MEM = 8'hCE;
  localparam logic [7:0] OP_PREFIX_EXT = 8'hCF;
  localparam logic [7:0] OP_ACC_IMM = 8'hC0;
  localparam logic [7:0] OP_PTR_IMM = 8'hC1;
  localparam logic [7:0] OP_IDX_X_IMM = 8'hC2;
  localparam logic [7:0] OP_IDX_Y_IMM = 8'hC3;
  localparam logic [6:0] SUB_MEM_ADD = 7'h03;
  localparam logic [5:0] SUB_ACC_RP = 6'h00;
  localparam logic [5:0] SUB_PTR_RP = 6'h08;
  localparam logic [6:0] SUB_IDX_X_RP = 7'h20;
  localparam logic [6:0] SUB_IDX_Y_RP = 7'h21;
  localparam logic [6:0] SUB_SP_RP = 7'h22;
  localparam logic [7:0] SUB_SP_IMM = 8'h6E;

  localparam logic [2:0] LEN_MEM = 3'h5;
  localparam logic [2:0] LEN_IMM = 3'h3;
  localparam logic [2:0] LEN_RP = 3'h4;
  localparam logic [2:0] LEN_SP_IMM = 3'h4;
  localparam logic [2:0] CYC_FIRST = 3'h1;
  localparam logic [2:0] CYC_EXEC = 3'h2;
  localparam logic [2:0] CYC_SRC_RD = 3'h2;
  localparam logic [2:0] CYC_DST_RD = 3'h3;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;

  localparam logic [1:0] SRC_ACC = 2'h0;
  localparam logic [1:0] SRC_PTR = 2'h1;
  localparam logic [1:0] SRC_IDX_X = 2'h2;
  localparam logic [1:0] SRC_IDX_Y = 2'h3;

  localparam int FLG_N = 3;
  localparam int FLG_V = 2;
  localparam int FLG_C = 1;
  localparam int FLG_Z = 0;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [15:0] PAIR_RST = 16'h0000;
  localparam logic [7:0] PAGE_FLAT = 8'h00;
  localparam logic [4:0] BCD_LIMIT = 5'h09;
  localparam logic [4:0] BCD_ADJ = 5'h06;

  typedef enum logic [2:0] {
    DST_ACC = 3'h0,
    DST_PTR = 3'h1,
    DST_IDX_X = 3'h2,
    DST_IDX_Y = 3'h3,
    DST_SP = 3'h4,
    DST_MEM = 3'h5
  } wad_dst_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SUB = 2'b01,
    ST_EXEC = 2'b11
  } wad_state_t;
endpackage
